// ===== hdl/pnl_regs.svh
`ifndef PNL_REGS_SVH
`define PNL_REGS_SVH
`define PNL_SEL_W 5
`define PNL_SEL_MEM_DATA 5'h00
`define PNL_SEL_SCR2 5'h01
`define PNL_SEL_SCR3 5'h02
`define PNL_SEL_STK_TOP 5'h03
`define PNL_SEL_STK_2ND 5'h04
`define PNL_SEL_STK_3RD 5'h05
`define PNL_SEL_STK_HEAD 5'h06
`define PNL_SEL_STATUS 5'h07
`define PNL_SEL_PROG_BASE 5'h08
`define PNL_SEL_PROG_CNT 5'h09
`define PNL_SEL_CODE_LIM 5'h0a
`define PNL_SEL_DATA_LIM 5'h0b
`define PNL_SEL_DATA_BASE 5'h0c
`define PNL_SEL_STK_MARK 5'h0d
`define PNL_SEL_STK_PTR 5'h0e
`define PNL_SEL_STK_LIM 5'h0f
`define PNL_SEL_UCNT 5'h10
`define PNL_SEL_CUR_INSN 5'h11
`define PNL_SEL_COUNT 18
`define PNL_UCNT_LSB 10
`define PNL_UCNT_W 6
`define PNL_WORD_RST 16'h0000
`define PNL_BANK_RST 2'h0
`endif

// ===== hdl/pnl_pkg.sv
package pnl_pkg;
  typedef logic [15:0] pnl_word_t;
  typedef logic [1:0] pnl_bank_t;
  typedef struct packed {
    pnl_word_t scr2;
    pnl_word_t scr3;
    pnl_word_t stk_top;
    pnl_word_t stk_2nd;
    pnl_word_t stk_3rd;
    pnl_word_t stk_head;
    pnl_word_t status;
    pnl_word_t prog_base;
    pnl_word_t prog_cnt;
    pnl_word_t code_lim;
    pnl_word_t data_lim;
    pnl_word_t data_base;
    pnl_word_t stk_mark;
    pnl_word_t stk_ptr;
    pnl_word_t stk_lim;
    logic [5:0] ucnt;
    pnl_word_t cur_insn;
    pnl_bank_t prog_bank;
    pnl_bank_t data_bank;
    pnl_bank_t stk_bank;
  } pnl_cpu_regs_t;
  typedef struct packed {
    logic rd_valid;
    pnl_word_t rd_data;
    logic wr_valid;
    pnl_word_t wr_data;
  } pnl_mem_obs_t;
  typedef struct packed {
    logic load_pulse;
    logic store_pulse;
    logic exec_pulse;
    logic [4:0] sel;
    pnl_word_t word;
  } pnl_cmd_t;
endpackage : pnl_pkg

// ===== hdl/pnl_mux.sv
`timescale 1ns/1ns
`include "pnl_regs.svh"
module pnl_mux
  import pnl_pkg::*;
(
  input wire logic [4:0] sel_i,
  input wire pnl_word_t mem_data_i,
  input wire pnl_cpu_regs_t regs_i,
  output logic [15:0] word_o,
  output logic [1:0] bank_o
);
  always_comb begin
    word_o = `PNL_WORD_RST;
    bank_o = `PNL_BANK_RST;
    case (sel_i)
      `PNL_SEL_MEM_DATA: word_o = mem_data_i;
      `PNL_SEL_SCR2: word_o = regs_i.scr2;
      `PNL_SEL_SCR3: word_o = regs_i.scr3;
      `PNL_SEL_STK_TOP: word_o = regs_i.stk_top;
      `PNL_SEL_STK_2ND: word_o = regs_i.stk_2nd;
      `PNL_SEL_STK_3RD: word_o = regs_i.stk_3rd;
      `PNL_SEL_STK_HEAD: word_o = regs_i.stk_head;
      `PNL_SEL_STATUS: word_o = regs_i.status;
      `PNL_SEL_PROG_BASE: begin
        word_o = regs_i.prog_base;
        bank_o = regs_i.prog_bank;
      end
      `PNL_SEL_PROG_CNT: begin
        word_o = regs_i.prog_cnt;
        bank_o = regs_i.prog_bank;
      end
      `PNL_SEL_CODE_LIM: begin
        word_o = regs_i.code_lim;
        bank_o = regs_i.prog_bank;
      end
      `PNL_SEL_DATA_LIM: begin
        word_o = regs_i.data_lim;
        bank_o = regs_i.stk_bank;
      end
      `PNL_SEL_DATA_BASE: begin
        word_o = regs_i.data_base;
        bank_o = regs_i.data_bank;
      end
      `PNL_SEL_STK_MARK: begin
        word_o = regs_i.stk_mark;
        bank_o = regs_i.stk_bank;
      end
      `PNL_SEL_STK_PTR: begin
        word_o = regs_i.stk_ptr;
        bank_o = regs_i.stk_bank;
      end
      `PNL_SEL_STK_LIM: begin
        word_o = regs_i.stk_lim;
        bank_o = regs_i.stk_bank;
      end
      `PNL_SEL_UCNT: word_o[`PNL_UCNT_LSB +: `PNL_UCNT_W] = regs_i.ucnt;
      `PNL_SEL_CUR_INSN: word_o = regs_i.cur_insn;
      default: begin
        word_o = `PNL_WORD_RST;
        bank_o = `PNL_BANK_RST;
      end
    endcase
  end
endmodule : pnl_mux

// ===== hdl/pnl_panel.sv
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`include "pnl_regs.svh"
module pnl_panel
  import pnl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [4:0] select_i,
  input wire logic [15:0] switch_word_i,
  input wire logic [1:0] switch_bank_i,
  input wire logic load_from_switches_i,
  input wire logic mem_display_i,
  input wire logic mem_store_i,
  input wire logic execute_switch_word_i,
  input wire logic addr_from_display_i,
  input wire logic clock_inhibit_i,
  input wire logic bkpt_read_en_i,
  input wire logic bkpt_store_en_i,
  input wire logic bkpt_clear_i,
  input wire pnl_cpu_regs_t cpu_regs_i,
  input wire pnl_mem_obs_t mem_obs_i,
  output logic [15:0] display_o,
  output logic bank_lamp_high_o,
  output logic bank_lamp_low_o,
  output logic display_valid_o,
  output pnl_cmd_t cmd_o,
  output logic mem_read_req_o,
  output logic mem_write_req_o,
  output logic [15:0] mem_wdata_o,
  output logic [15:0] mem_addr_o,
  output logic [1:0] abs_bank_o,
  output logic bkpt_halt_o
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01
  } pnl_state_t;

  typedef struct packed {
    pnl_state_t st;
    logic [4:0] sel;
    pnl_word_t mem_data;
    pnl_word_t disp;
    pnl_bank_t bank;
    logic valid;
    pnl_cmd_t cmd;
    logic rd_req;
    logic wr_req;
    pnl_word_t wdata;
    pnl_word_t addr;
    pnl_bank_t abs_bank;
    logic halt;
  } pnl_state_s_t;

  pnl_state_s_t s_q;
  pnl_state_s_t s_d;
  pnl_word_t mux_word;
  pnl_bank_t mux_bank;
  logic sel_ok;
  logic rd_hit;
  logic wr_hit;

  pnl_mux u_mux (
    .sel_i(s_q.sel),
    .mem_data_i(s_q.mem_data),
    .regs_i(cpu_regs_i),
    .word_o(mux_word),
    .bank_o(mux_bank)
  );

  assign sel_ok = (select_i < 5'(`PNL_SEL_COUNT));
  assign rd_hit = bkpt_read_en_i && mem_obs_i.rd_valid
    && (mem_obs_i.rd_data == switch_word_i);
  assign wr_hit = bkpt_store_en_i && mem_obs_i.wr_valid
    && (mem_obs_i.wr_data == switch_word_i);

  always_comb begin
    s_d = s_q;
    s_d.cmd.load_pulse = 1'b0;
    s_d.cmd.store_pulse = 1'b0;
    s_d.cmd.exec_pulse = 1'b0;
    s_d.rd_req = 1'b0;
    s_d.wr_req = 1'b0;
    if (sel_ok) begin
      s_d.sel = select_i;
    end
    s_d.disp = mux_word;
    s_d.bank = mux_bank;
    s_d.valid = (s_q.sel != `PNL_SEL_CUR_INSN) || clock_inhibit_i;
    s_d.cmd.sel = s_q.sel;
    s_d.cmd.word = switch_word_i;
    if (load_from_switches_i && s_q.sel != `PNL_SEL_CUR_INSN
        && s_q.sel != `PNL_SEL_STATUS) begin
      s_d.cmd.load_pulse = 1'b1;
      if (s_q.sel == `PNL_SEL_MEM_DATA) begin
        s_d.mem_data = switch_word_i;
      end
      if (s_q.sel == `PNL_SEL_UCNT) begin
        s_d.cmd.word = {switch_word_i[15:10], 10'h000};
      end
    end
    if (addr_from_display_i) begin
      s_d.addr = s_q.disp;
      s_d.abs_bank = s_q.bank;
    end
    if (execute_switch_word_i) begin
      s_d.cmd.exec_pulse = 1'b1;
    end
    unique case (s_q.st)
      ST_IDLE: begin
        if (mem_store_i) begin
          s_d.wr_req = 1'b1;
          s_d.wdata = switch_word_i;
          s_d.cmd.store_pulse = 1'b1;
        end else if (mem_display_i) begin
          s_d.rd_req = 1'b1;
          s_d.st = ST_READ;
        end
      end
      ST_READ: begin
        if (mem_obs_i.rd_valid) begin
          s_d.mem_data = mem_obs_i.rd_data;
          s_d.st = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    if (bkpt_clear_i) begin
      s_d.halt = 1'b0;
    end
    if (rd_hit || wr_hit) begin
      s_d.halt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign display_o = s_q.disp;
  assign bank_lamp_high_o = s_q.bank[1];
  assign bank_lamp_low_o = s_q.bank[0];
  assign display_valid_o = s_q.valid;
  assign cmd_o = s_q.cmd;
  assign mem_read_req_o = s_q.rd_req;
  assign mem_write_req_o = s_q.wr_req;
  assign mem_wdata_o = s_q.wdata;
  assign mem_addr_o = s_q.addr;
  assign abs_bank_o = s_q.abs_bank;
  assign bkpt_halt_o = s_q.halt;

  property p_rd_bkpt;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      rd_hit |=> bkpt_halt_o;
  endproperty
  a_rd_bkpt: assert property (p_rd_bkpt) else $error("read match did not halt");

  property p_wr_bkpt;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      wr_hit |=> bkpt_halt_o;
  endproperty
  a_wr_bkpt: assert property (p_wr_bkpt) else $error("store match did not halt");

  property p_memdata;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (s_q.sel == `PNL_SEL_MEM_DATA) |=> (display_o == $past(s_q.mem_data))
        && !bank_lamp_high_o && !bank_lamp_low_o;
  endproperty
  a_memdata: assert property (p_memdata) else $error("memory data display wrong");

  property p_fetch;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (s_q.st == ST_READ && mem_obs_i.rd_valid) |=> s_q.mem_data == $past(mem_obs_i.rd_data);
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetched word not captured");

  property p_pbank;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (s_q.sel == `PNL_SEL_PROG_CNT) |=> {bank_lamp_high_o, bank_lamp_low_o}
        == $past(cpu_regs_i.prog_bank) && display_o == $past(cpu_regs_i.prog_cnt);
  endproperty
  a_pbank: assert property (p_pbank) else $error("program counter display wrong");

  property p_ucnt;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (s_q.sel == `PNL_SEL_UCNT) |=> display_o[9:0] == 10'h000
        && display_o[15:10] == $past(cpu_regs_i.ucnt);
  endproperty
  a_ucnt: assert property (p_ucnt) else $error("counter display wrong");

  property p_store;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (mem_store_i && s_q.st == ST_IDLE) |=> mem_write_req_o
        && mem_wdata_o == $past(switch_word_i);
  endproperty
  a_store: assert property (p_store) else $error("store did not issue");

  property p_exec;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (execute_switch_word_i && !load_from_switches_i) |=> cmd_o.exec_pulse
        && cmd_o.word == $past(switch_word_i);
  endproperty
  a_exec: assert property (p_exec) else $error("execute did not issue");

  property p_addr;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      addr_from_display_i |=> mem_addr_o == $past(display_o);
  endproperty
  a_addr: assert property (p_addr) else $error("address not from display");
endmodule : pnl_panel

// ===== verification/pnl_mem_model.sv
`timescale 1ns/1ns
module pnl_mem_model
  import pnl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic slow_i,
  input wire logic mem_read_req_i,
  input wire logic mem_write_req_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic [15:0] mem_wdata_i,
  output pnl_mem_obs_t mem_obs_o
);
  pnl_word_t mem_q [16];
  logic [3:0] wait_q = 4'h0;
  logic [3:0] rd_addr_q = 4'h0;
  initial begin
    mem_obs_o = '0;
    foreach (mem_q[i]) mem_q[i] = 16'h0a50 + 16'(i);
  end
  // stale data flips every cycle so nothing is read from a dead bus
  always @(posedge sys_clk_i) begin
    mem_obs_o.rd_valid <= 1'b0;
    mem_obs_o.wr_valid <= 1'b0;
    mem_obs_o.rd_data <= ~mem_obs_o.rd_data;
    mem_obs_o.wr_data <= ~mem_obs_o.wr_data;
    if (mem_read_req_i) begin
      rd_addr_q <= mem_addr_i[3:0];
      wait_q <= slow_i ? 4'h5 : 4'h1;
    end else if (wait_q == 4'h1) begin
      mem_obs_o.rd_valid <= 1'b1;
      mem_obs_o.rd_data <= mem_q[rd_addr_q];
      wait_q <= 4'h0;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end
    if (mem_write_req_i) begin
      mem_q[mem_addr_i[3:0]] <= mem_wdata_i;
      mem_obs_o.wr_valid <= 1'b1;
      mem_obs_o.wr_data <= mem_wdata_i;
    end
  end
endmodule : pnl_mem_model

// ===== verification/panel_register_display_tb.sv
`timescale 1ns/1ns
`include "pnl_regs.svh"
module panel_register_display_tb;
  import pnl_pkg::*;
  localparam int LD = 0, MD = 1, MS = 2, EX = 3, AD = 4, CL = 5;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [4:0] select_i = 5'h00;
  logic [5:0] btn = 6'h00;
  pnl_word_t sw = 16'h0000;
  logic inh = 1'b0, bre = 1'b0, bse = 1'b0, slow = 1'b0;
  pnl_cpu_regs_t regs;
  pnl_mem_obs_t obs;
  pnl_cmd_t cmd;
  logic [15:0] display_o, wdata, addr;
  logic hi, lo, valid, rreq, wreq, halt;
  logic [1:0] abank;
  int n_fail = 0;
  int cmp_count = 0;
  pnl_panel DUT (.sys_clk_i, .sys_rst_i, .select_i, .switch_word_i(sw), .switch_bank_i(2'h3),
    .load_from_switches_i(btn[LD]), .mem_display_i(btn[MD]), .mem_store_i(btn[MS]),
    .execute_switch_word_i(btn[EX]), .addr_from_display_i(btn[AD]), .clock_inhibit_i(inh),
    .bkpt_read_en_i(bre), .bkpt_store_en_i(bse), .bkpt_clear_i(btn[CL]), .cpu_regs_i(regs),
    .mem_obs_i(obs), .display_o, .bank_lamp_high_o(hi), .bank_lamp_low_o(lo),
    .display_valid_o(valid), .cmd_o(cmd), .mem_read_req_o(rreq), .mem_write_req_o(wreq),
    .mem_wdata_o(wdata), .mem_addr_o(addr), .abs_bank_o(abank), .bkpt_halt_o(halt));
  pnl_mem_model MEM (.sys_clk_i, .slow_i(slow), .mem_read_req_i(rreq), .mem_write_req_i(wreq),
    .mem_addr_i(addr), .mem_wdata_i(wdata), .mem_obs_o(obs));
  always #10 sys_clk_i = ~sys_clk_i;
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : step
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic pick(input logic [4:0] s);
    @(posedge sys_clk_i);
    select_i <= s;
    step(3);
  endtask : pick
  task automatic press(input int k);
    @(posedge sys_clk_i);
    btn[k] <= 1'b1;
    @(posedge sys_clk_i);
    btn[k] <= 1'b0;
    #1;
  endtask : press
  function automatic logic [17:0] exp_of(input logic [4:0] s);
    case (s)
      `PNL_SEL_SCR2: return {2'h0, regs.scr2};
      `PNL_SEL_SCR3: return {2'h0, regs.scr3};
      `PNL_SEL_STK_TOP: return {2'h0, regs.stk_top};
      `PNL_SEL_STK_2ND: return {2'h0, regs.stk_2nd};
      `PNL_SEL_STK_3RD: return {2'h0, regs.stk_3rd};
      `PNL_SEL_STK_HEAD: return {2'h0, regs.stk_head};
      `PNL_SEL_STATUS: return {2'h0, regs.status};
      `PNL_SEL_PROG_BASE: return {regs.prog_bank, regs.prog_base};
      `PNL_SEL_PROG_CNT: return {regs.prog_bank, regs.prog_cnt};
      `PNL_SEL_CODE_LIM: return {regs.prog_bank, regs.code_lim};
      `PNL_SEL_DATA_LIM: return {regs.stk_bank, regs.data_lim};
      `PNL_SEL_DATA_BASE: return {regs.data_bank, regs.data_base};
      `PNL_SEL_STK_MARK: return {regs.stk_bank, regs.stk_mark};
      `PNL_SEL_STK_PTR: return {regs.stk_bank, regs.stk_ptr};
      `PNL_SEL_STK_LIM: return {regs.stk_bank, regs.stk_lim};
      `PNL_SEL_UCNT: return {2'h0, regs.ucnt, 10'h000};
      `PNL_SEL_CUR_INSN: return {2'h0, regs.cur_insn};
      default: return 18'h0;
    endcase
  endfunction : exp_of
  task automatic sweep(input logic [4:0] a, input logic [4:0] b);
    for (logic [5:0] s = {1'b0, a}; s <= {1'b0, b}; s++) begin
      pick(s[4:0]);
      chk("lamps", {hi, lo, display_o}, exp_of(s[4:0]));
    end
  endtask : sweep
  task automatic do_load(input logic [4:0] s, input logic ok, input pnl_word_t w);
    pick(s);
    press(LD);
    chk("load pulse", cmd.load_pulse, ok);
    if (ok) chk("load cmd", {cmd.sel, cmd.word}, {s, w});
  endtask : do_load
  initial begin
    #50000;
    n_fail++;
    close_out();
  end
  initial begin
    for (int i = 0; i < $bits(regs); i++) regs[i] = ((i * i) % 7) > 2;
    regs.prog_bank = 2'h1;
    regs.data_bank = 2'h2;
    regs.stk_bank = 2'h3;
    repeat (5) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    step(1);
    chk("reset lamps", {hi, lo, display_o}, 18'h0);
    sweep(`PNL_SEL_SCR2, `PNL_SEL_STATUS);
    sweep(`PNL_SEL_PROG_BASE, `PNL_SEL_CUR_INSN);
    chk("valid free run", valid, 1'b0);
    @(posedge sys_clk_i);
    inh <= 1'b1;
    step(2);
    chk("valid inhibited", valid, 1'b1);
    pick(5'h1f);
    chk("bad code", {hi, lo, display_o}, exp_of(`PNL_SEL_CUR_INSN));
    @(posedge sys_clk_i);
    regs.cur_insn <= 16'h0f0f;
    step(2);
    chk("live refresh", {hi, lo, display_o}, 18'h00f0f);
    $display("test done: display selections");
    @(posedge sys_clk_i);
    sw <= 16'hfc3c;
    do_load(`PNL_SEL_STK_TOP, 1'b1, 16'hfc3c);
    do_load(`PNL_SEL_UCNT, 1'b1, 16'hfc00);
    do_load(`PNL_SEL_STATUS, 1'b0, 16'h0000);
    do_load(`PNL_SEL_CUR_INSN, 1'b0, 16'h0000);
    press(EX);
    chk("exec", {cmd.exec_pulse, cmd.load_pulse, cmd.word}, {2'b10, 16'hfc3c});
    $display("test done: switch loads");
    pick(`PNL_SEL_PROG_CNT);
    press(AD);
    step(1);
    chk("address", {abank, addr}, exp_of(`PNL_SEL_PROG_CNT));
    press(MS);
    chk("store", {wreq, cmd.store_pulse, wdata}, {2'b11, 16'hfc3c});
    step(8);
    chk("halt off", halt, 1'b0);
    @(posedge sys_clk_i);
    sw <= 16'h1234;
    slow <= 1'b1;
    bre <= 1'b1;
    pick(`PNL_SEL_MEM_DATA);
    press(MD);
    chk("read req", rreq, 1'b1);
    press(MS);
    chk("store refused", wreq, 1'b0);
    step(12);
    chk("mem data", {hi, lo, display_o}, 18'h0fc3c);
    chk("no match", halt, 1'b0);
    @(posedge sys_clk_i);
    sw <= 16'hfc3c;
    slow <= 1'b0;
    press(MD);
    step(8);
    chk("read halt", halt, 1'b1);
    @(posedge sys_clk_i);
    bre <= 1'b0;
    press(CL);
    step(1);
    chk("cleared", halt, 1'b0);
    @(posedge sys_clk_i);
    bse <= 1'b1;
    press(MS);
    step(8);
    chk("store halt", halt, 1'b1);
    @(posedge sys_clk_i);
    sw <= 16'h5a5a;
    do_load(`PNL_SEL_MEM_DATA, 1'b1, 16'h5a5a);
    step(1);
    chk("scratch load", {hi, lo, display_o}, 18'h05a5a);
    $display("test done: memory and breakpoints");
    close_out();
  end
endmodule : panel_register_display_tb
